//--- hdl/rps_defines.svh
`ifndef RPS_DEFINES_SVH
`define RPS_DEFINES_SVH

// selector field geometry
`define RPS_SEL_W 5
`define RPS_EVEN_LSB 0
`define RPS_ODD_LSB 8
`define RPS_DATA_W 16
`define RPS_ADDR_W 4

// selector codes and reset values
`define RPS_SEL_GROUND 5'h1f
`define RPS_SEL_MAX_PIN 5'h19
`define RPS_SEL_NONE 5'h00
`define RPS_IN_RESET 5'h1f
`define RPS_OUT_RESET 5'h00

// pin and function counts
`define RPS_IN_PINS 26
`define RPS_OUT_PINS 16
`define RPS_OUT_REGS 8
`define RPS_FUNCS 32

// register word indices on the plain register port
`define RPS_OFF_CAN_RX 4'h0
`define RPS_OFF_OUT_BASE 4'h1
`define RPS_OFF_OUT_LAST 4'h8

`endif

//--- hdl/rps_in_sel.sv
`timescale 1ns/10ps
`include "rps_defines.svh"

module rps_in_sel (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [`RPS_IN_PINS-1:0] remappable_pin,
  input wire rps_pkg::rps_sel_t src_sel,
  input wire logic enable,
  output logic can_receive_input
);

  logic [`RPS_IN_PINS-1:0] pin_meta;
  logic [`RPS_IN_PINS-1:0] pin_sync;
  logic next_rx;

  // pin value or ground level
  always_comb begin
    next_rx = 1'b0;
    if (enable && (src_sel <= `RPS_SEL_MAX_PIN)) begin
      next_rx = pin_sync[src_sel];
    end
    // ground code and unused codes give ground
  end

  // two-stage pin synchroniser and output flop
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta <= '0;
      pin_sync <= '0;
      can_receive_input <= 1'b0;
    end else begin
      pin_meta <= remappable_pin;
      pin_sync <= pin_meta;
      can_receive_input <= next_rx;
    end
  end

  a_rx_follows_pin: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (enable && src_sel <= `RPS_SEL_MAX_PIN) |=> can_receive_input == $past(pin_sync[src_sel]))
    else $error("receive input does not follow the selected pin");

  a_rx_ground_code: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (src_sel == `RPS_SEL_GROUND) |=> !can_receive_input)
    else $error("receive input not grounded on all-ones code");

endmodule // rps_in_sel

//--- hdl/rps_out_sel.sv
`timescale 1ns/10ps
`include "rps_defines.svh"

module rps_out_sel (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire rps_pkg::rps_sel_t func_sel,
  input wire logic [`RPS_FUNCS-1:0] periph_func_out,
  output rps_pkg::rps_pin_drive_t drive
);

  rps_pkg::rps_pin_drive_t next_drive;

  // function zero leaves the pin to its port logic
  always_comb begin
    next_drive = '0;
    if (func_sel != `RPS_SEL_NONE) begin
      next_drive.active = 1'b1;
      next_drive.level = periph_func_out[func_sel];
    end
  end

  // registered pin drive
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      drive <= '0;
    end else begin
      drive <= next_drive;
    end
  end

  a_out_route_func: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (func_sel != `RPS_SEL_NONE) |=> drive.active && drive.level == $past(periph_func_out[func_sel]))
    else $error("pin not driven by selected function");

  a_out_zero_idle: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (func_sel == `RPS_SEL_NONE) |=> !drive.active && !drive.level)
    else $error("pin claimed with function zero");

endmodule // rps_out_sel

//--- hdl/rps_pin_select.sv
`timescale 1ns/10ps
`include "rps_defines.svh"
module rps_pin_select #(
  parameter bit HAS_CAN = 1'b1
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [`RPS_ADDR_W-1:0] reg_addr,
  input wire logic [`RPS_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`RPS_DATA_W-1:0] reg_rdata,
  input wire logic [`RPS_IN_PINS-1:0] remappable_pin,
  input wire logic [`RPS_FUNCS-1:0] periph_func_out,
  output logic can_receive_input,
  output logic [`RPS_OUT_PINS-1:0] pin_remap_active,
  output logic [`RPS_OUT_PINS-1:0] pin_remap_level
);

  // decode of output map word indices
  function automatic logic is_out_map(input logic [`RPS_ADDR_W-1:0] addr);
    is_out_map = (addr >= `RPS_OFF_OUT_BASE) && (addr <= `RPS_OFF_OUT_LAST);
  endfunction

  function automatic logic [2:0] map_slot(input logic [`RPS_ADDR_W-1:0] addr);
    logic [`RPS_ADDR_W-1:0] diff;
    diff = addr - `RPS_OFF_OUT_BASE;
    map_slot = diff[2:0];
  endfunction

  rps_pkg::rps_sel_t can_rx_source_select;
  rps_pkg::rps_sel_t next_can_rx_source_select;
  rps_pkg::rps_sel_t out_func [`RPS_OUT_PINS];
  rps_pkg::rps_sel_t next_out_func [`RPS_OUT_PINS];
  logic [`RPS_DATA_W-1:0] next_reg_rdata;
  rps_pkg::rps_map_word_t rd_word;
  logic [3:0] even_idx;
  logic [3:0] odd_idx;
  rps_pkg::rps_pin_drive_t pin_drive [`RPS_OUT_PINS];

  // word slot to pin pair
  assign even_idx = {map_slot(reg_addr), 1'b0};
  assign odd_idx = {map_slot(reg_addr), 1'b1};

  // selector writes; pad bits are dropped
  always_comb begin
    next_can_rx_source_select = can_rx_source_select;
    next_out_func = out_func;
    if (reg_wr) begin
      if (reg_addr == `RPS_OFF_CAN_RX) begin
        if (HAS_CAN) begin
          next_can_rx_source_select = reg_wdata[`RPS_SEL_W-1:0];
        end
      end else if (is_out_map(reg_addr)) begin
        next_out_func[even_idx] = reg_wdata[`RPS_EVEN_LSB +: `RPS_SEL_W];
        next_out_func[odd_idx] = reg_wdata[`RPS_ODD_LSB +: `RPS_SEL_W];
      end
    end
  end

  // selector storage with power-on defaults
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      can_rx_source_select <= `RPS_IN_RESET;
      for (int i = 0; i < `RPS_OUT_PINS; i++) begin
        out_func[i] <= `RPS_OUT_RESET;
      end
    end else begin
      can_rx_source_select <= next_can_rx_source_select;
      out_func <= next_out_func;
    end
  end

  // read word assembly, pads forced to zero
  always_comb begin
    rd_word = '0;
    next_reg_rdata = '0;
    if (reg_rd) begin
      if (reg_addr == `RPS_OFF_CAN_RX) begin
        if (HAS_CAN) begin
          rd_word.even_sel = can_rx_source_select;
        end
      end else if (is_out_map(reg_addr)) begin
        rd_word.even_sel = out_func[even_idx];
        rd_word.odd_sel = out_func[odd_idx];
      end
      next_reg_rdata = rd_word;
    end
  end

  // read data stands for one cycle only
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

  // receive input routing, disabled without the controller
  rps_in_sel u_in_sel (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .remappable_pin(remappable_pin),
    .src_sel(can_rx_source_select),
    .enable(HAS_CAN),
    .can_receive_input(can_receive_input)
  );

  // one output selector per remappable pin
  for (genvar g = 0; g < `RPS_OUT_PINS; g++) begin : g_out
    rps_out_sel u_out_sel (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .func_sel(out_func[g]),
      .periph_func_out(periph_func_out),
      .drive(pin_drive[g])
    );
    assign pin_remap_active[g] = pin_drive[g].active;
    assign pin_remap_level[g] = pin_drive[g].level;
  end

  a_sel_reset_value: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !$past(reset_n) |-> can_rx_source_select == `RPS_IN_RESET && out_func[0] == `RPS_OUT_RESET
      && out_func[15] == `RPS_OUT_RESET && !can_receive_input)
    else $error("selectors not at power-on values");

  a_rdata_idle_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !reg_rd |=> reg_rdata == '0)
    else $error("read data present without a read");

  a_pad_bits_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
    reg_rd |=> reg_rdata[15:13] == 3'h0 && reg_rdata[7:5] == 3'h0)
    else $error("pad bits read as nonzero");

  a_can_sel_readback: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (reg_rd && reg_addr == `RPS_OFF_CAN_RX) |=>
      reg_rdata == (HAS_CAN ? {11'h000, $past(can_rx_source_select)} : 16'h0000))
    else $error("receive selector read back wrong");

  a_can_write_takes: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (reg_wr && reg_addr == `RPS_OFF_CAN_RX) |=>
      can_rx_source_select == (HAS_CAN ? $past(reg_wdata[4:0]) : `RPS_IN_RESET))
    else $error("receive selector write not honoured");

  a_out_pair_split: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (reg_wr && is_out_map(reg_addr)) |=>
      out_func[$past(even_idx)] == $past(reg_wdata[4:0])
      && out_func[$past(odd_idx)] == $past(reg_wdata[12:8]))
    else $error("output map word split wrong");

  a_out_last_word: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (reg_wr && reg_addr == `RPS_OFF_OUT_LAST) |=>
      out_func[14] == $past(reg_wdata[4:0]) && out_func[15] == $past(reg_wdata[12:8])
      ##1 pin_remap_active[15] == ($past(out_func[15]) != 5'h00))
    else $error("last map word misplaced");

  a_ground_two_cycles: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (reg_wr && reg_addr == `RPS_OFF_CAN_RX && reg_wdata[4:0] == 5'h1f) |-> ##2 !can_receive_input)
    else $error("ground code did not ground the input");

endmodule // rps_pin_select

//--- hdl/rps_pkg.sv
`include "rps_defines.svh"

package rps_pkg;

  // one five-bit selector field
  typedef logic [`RPS_SEL_W-1:0] rps_sel_t;

  // one output map word: odd pin high, even pin low
  typedef struct packed {
    logic [2:0] pad_hi;
    rps_sel_t odd_sel;
    logic [2:0] pad_lo;
    rps_sel_t even_sel;
  } rps_map_word_t;

  // drive toward one remappable pin
  typedef struct packed {
    logic active;
    logic level;
  } rps_pin_drive_t;

endpackage

//--- sim/rps_far_model.sv
`timescale 1ns/10ps
`include "rps_defines.svh"

// stand-in for the pads and the on-chip peripherals on the far side
module rps_far_model (
  input wire logic sys_clk,
  input wire logic [`RPS_IN_PINS-1:0] pad_level,
  input wire logic [`RPS_FUNCS-1:0] func_level,
  output logic [`RPS_IN_PINS-1:0] remappable_pin,
  output logic [`RPS_FUNCS-1:0] periph_func_out
);
  // peripherals and pads launch new levels on the system clock
  always_ff @(posedge sys_clk) begin
    remappable_pin <= pad_level;
    periph_func_out <= func_level;
  end
endmodule // rps_far_model

//--- sim/test_remappable_pin_select.sv
`timescale 1ns/10ps
`include "rps_defines.svh"

module test_remappable_pin_select;
  logic sys_clk, reset_n, reg_wr, reg_rd, can_receive_input;
  logic [`RPS_ADDR_W-1:0] reg_addr;
  logic [`RPS_DATA_W-1:0] reg_wdata, reg_rdata;
  logic [`RPS_IN_PINS-1:0] pad_level, remappable_pin;
  logic [`RPS_FUNCS-1:0] func_level, periph_func_out;
  logic [`RPS_OUT_PINS-1:0] pin_remap_active, pin_remap_level;
  logic [`RPS_DATA_W-1:0] rdata_nc;
  logic rx_nc;
  int miscompares, checked;

  rps_pin_select uut (
    .sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .remappable_pin, .periph_func_out, .can_receive_input,
    .pin_remap_active, .pin_remap_level
  );

  // variant without the receive controller, same stimulus
  rps_pin_select #(.HAS_CAN(1'b0)) uut_nocan (
    .sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata(rdata_nc),
    .remappable_pin, .periph_func_out, .can_receive_input(rx_nc),
    .pin_remap_active(), .pin_remap_level()
  );

  rps_far_model far (
    .sys_clk, .pad_level, .func_level, .remappable_pin, .periph_func_out
  );

  // clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // compare and count
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // one-cycle read strobe, data looked at in the following cycle
  task automatic rd(logic [3:0] a, logic [15:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 check("reg_rdata", 32'(e), 32'(reg_rdata));
    if (a == `RPS_OFF_CAN_RX) check("nocan rdata", 32'h0, 32'(rdata_nc));
  endtask

  // wait for synchroniser and output flops to settle
  task automatic settle;
    repeat (6) @(posedge sys_clk);
    #1;
  endtask

  task automatic results;
    if (miscompares == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // hang guard
  initial begin
    #400000;
    miscompares++;
    results();
  end

  // main sequence
  initial begin
    logic [31:0] pat;
    reset_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    pad_level = '1;
    func_level = '0;
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    // reset values, grounded receive input
    rd(`RPS_OFF_CAN_RX, 16'h001f);
    for (int k = 0; k < 8; k++) rd(4'(k + 1), 16'h0000);
    settle();
    check("grounded rx", 32'h0, 32'(can_receive_input));
    // reserved bits and unmapped words
    wr(`RPS_OFF_CAN_RX, 16'hffe7);
    rd(`RPS_OFF_CAN_RX, 16'h0007);
    wr(4'h1, 16'hffff);
    rd(4'h1, 16'h1f1f);
    wr(4'h9, 16'hffff);
    rd(4'h9, 16'h0000);
    rd(4'h2, 16'h0000);
    // every pin code reaches the receive input
    for (int k = 0; k < `RPS_IN_PINS; k++) begin
      wr(`RPS_OFF_CAN_RX, 16'(k));
      pad_level <= 26'(1) << k;
      settle();
      check("rx high", 32'h1, 32'(can_receive_input));
      check("nocan rx", 32'h0, 32'(rx_nc));
      pad_level <= ~(26'(1) << k);
      settle();
      check("rx low", 32'h0, 32'(can_receive_input));
    end
    wr(`RPS_OFF_CAN_RX, 16'h001f);
    pad_level <= '1;
    settle();
    check("ground code", 32'h0, 32'(can_receive_input));
    // pin p takes function p+1
    for (int k = 0; k < 8; k++) wr(4'(k + 1), {8'(2 * k + 2), 8'(2 * k + 1)});
    for (int k = 0; k < 8; k++) rd(4'(k + 1), {8'(2 * k + 2), 8'(2 * k + 1)});
    pat = 32'hc3a56e4b;
    repeat (2) begin
      func_level <= pat;
      settle();
      check("active", 32'hffff, 32'(pin_remap_active));
      check("level", 32'(pat[16:1]), 32'(pin_remap_level));
      pat = ~pat;
    end
    // selector zero hands pins back to the port
    for (int k = 0; k < 8; k++) wr(4'(k + 1), 16'h0000);
    settle();
    check("active off", 32'h0, 32'(pin_remap_active));
    check("level off", 32'h0, 32'(pin_remap_level));
    results();
  end
endmodule // test_remappable_pin_select
